/* design/sync_slave_receiver.sv */
// Synchronous slave receive path with APB register file
// ----------------------------------------------------------------
// Functional notes
// - Single-receive bit ignored in slave mode
// - Reception continues while asleep if enabled
// - Completed word moves to holding register
// - Enabled completion interrupt wakes from sleep
// - Nine-bit words when nine-bit select set
// - Reception starts only on continuous enable
// - Completion sets flag; interrupt needs enable
// - Status shows ninth bit and errors
// - Holding read returns low eight bits
// - Clearing continuous enable clears errors
// - Receive status bit layout as documented
// - Transmit status layout, resets to 0x02
// - Data sampled on shift clock falling edge
module sync_slave_receiver
  import sync_rx_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Serial pins
  input  wire logic        shift_clk_pin,
  input  wire logic        data_pin,
  // Core sleep and events
  output logic             asleep_q,
  output logic             irq_q,
  output logic             wake_q
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0]   int_global_q;
  logic [7:0]   periph_enables_q;
  logic [7:0]   periph_priority_q;
  logic [7:0]   baud_divisor_q;
  logic [7:0]   tx_ctrl_q;
  logic         port_enable_q;
  logic         nine_bit_q;
  logic         single_rx_q;
  logic         cont_rx_q;
  logic         overrun_q;
  logic         framing_q;
  logic         rx_flag_q;
  rx_word_type  holding_q;
  logic         holding_full_q;

  // Shifter
  rx_state_type state_q;
  logic [8:0]   shift_q;
  logic [3:0]   bit_cnt_q;
  logic         clk_lvl_q;
  logic         clk_sync;
  logic         data_sync;
  logic         fall_edge;
  logic         word_done;
  logic [3:0]   word_len;
  rx_word_type  done_word;

  // Buffer wires
  logic         buf_in_ready;
  logic         buf_out_valid;
  rx_word_type  buf_out_data;
  logic         take_word;

  // Bus decode
  logic         apb_write;
  logic         apb_read;
  logic         addr_ok;
  logic         holding_read;
  logic         cont_clear;
  logic         rx_running;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  pin_sync u_clk_sync (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .pin_in  (shift_clk_pin),
    .level_q (clk_sync)
  );

  pin_sync u_data_sync (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .pin_in  (data_pin),
    .level_q (data_sync)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic addr_match(input logic [7:0] a);
    case (a)
      ADDR_INTERRUPT_GLOBAL_CONTROL, ADDR_PERIPHERAL_FLAGS_ONE,
      ADDR_PERIPHERAL_ENABLES_ONE, ADDR_PERIPHERAL_PRIORITY_ONE,
      ADDR_RECEIVE_STATUS_CONTROL, ADDR_RECEIVE_HOLDING,
      ADDR_TRANSMIT_STATUS_CONTROL, ADDR_BAUD_DIVISOR,
      ADDR_SLEEP_CONTROL: addr_match = 1'b1;
      default:            addr_match = 1'b0;
    endcase
  endfunction : addr_match

  assign apb_write    = psel && penable && pwrite;
  assign apb_read     = psel && penable && !pwrite;
  assign addr_ok      = addr_match(paddr);
  assign holding_read = apb_read && (paddr == ADDR_RECEIVE_HOLDING);
  assign cont_clear   = apb_write && (paddr == ADDR_RECEIVE_STATUS_CONTROL)
                        && !pwdata[RCS_CONT_RX];

  // Slave mode needs sync mode, port enable and external clock; the single-receive
  // bit takes no part, so only the continuous enable starts a word
  assign rx_running = port_enable_q && cont_rx_q
                      && tx_ctrl_q[TXS_SYNC_MODE] && !tx_ctrl_q[TXS_CLOCK_SOURCE];

  // ----------------------------------------------------------------
  // Shift clock edge detection
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_lvl_q <= 1'b0;
    end else begin
      clk_lvl_q <= clk_sync;
    end
  end

  // The shifter runs off ref_clk, which is kept running while asleep
  assign fall_edge = clk_lvl_q && !clk_sync;
  assign word_len  = nine_bit_q ? 4'(WORD_BITS_LONG) : 4'(WORD_BITS_SHORT);
  assign word_done = (state_q == RX_SHIFT) && fall_edge && (bit_cnt_q == word_len - 4'd1);
  // Data arrives LSB first; an eight-bit word sits in the top bits of the shifter
  assign done_word.ninth_bit = nine_bit_q ? data_sync : 1'b0;
  assign done_word.data      = nine_bit_q ? shift_q[8:1] : {data_sync, shift_q[8:2]};

  // ----------------------------------------------------------------
  // Receive state machine
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q   <= RX_IDLE;
      bit_cnt_q <= 4'h0;
      shift_q   <= 9'h000;
    end else begin
      case (state_q)
        RX_IDLE: begin
          bit_cnt_q <= 4'h0;
          if (rx_running) begin
            state_q <= RX_SHIFT;
          end
        end
        RX_SHIFT: begin
          if (!rx_running) begin
            state_q <= RX_IDLE;
          end else if (word_done) begin
            bit_cnt_q <= 4'h0;
            // A word that finds no room is the overrun case
            if (!buf_in_ready) begin
              state_q <= RX_BLOCKED;
            end
          end else if (fall_edge) begin
            shift_q   <= {data_sync, shift_q[8:1]};
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end
        end
        RX_BLOCKED: begin
          if (cont_clear || !rx_running) begin
            state_q <= RX_IDLE;
          end
        end
        default: begin
          state_q <= RX_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Buffer between shifter and holding register
  // ----------------------------------------------------------------
  word_buffer #(
    .WIDTH ($bits(rx_word_type))
  ) u_buffer (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .flush     (1'b0),
    .in_valid  (word_done && rx_running),
    .in_ready  (buf_in_ready),
    .in_data   (done_word),
    .out_valid (buf_out_valid),
    .out_ready (!holding_full_q || holding_read),
    .out_data  (buf_out_data)
  );

  assign take_word = buf_out_valid && (!holding_full_q || holding_read);

  // ----------------------------------------------------------------
  // Holding register and completion flag
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      holding_q      <= '0;
      holding_full_q <= 1'b0;
    end else if (take_word) begin
      holding_q      <= buf_out_data;
      holding_full_q <= 1'b1;
    end else if (holding_read) begin
      holding_full_q <= 1'b0;
    end
  end

  // Flag follows the holding register: set on a new word, cleared by reading it
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_flag_q <= 1'b0;
    end else if (take_word) begin
      rx_flag_q <= 1'b1;
    end else if (holding_read) begin
      rx_flag_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Error flags
  // ----------------------------------------------------------------
  // Set wins over the clear; framing has no meaning in synchronous mode
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      overrun_q <= 1'b0;
      framing_q <= 1'b0;
    end else if (word_done && rx_running && !buf_in_ready) begin
      overrun_q <= 1'b1;
    end else if (cont_clear || !cont_rx_q) begin
      overrun_q <= 1'b0;
      framing_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      int_global_q      <= RST_INTERRUPT_GLOBAL;
      periph_enables_q  <= RST_PERIPH_ENABLES;
      periph_priority_q <= RST_PERIPH_PRIORITY;
      baud_divisor_q    <= RST_BAUD_DIVISOR;
      tx_ctrl_q         <= RST_TRANSMIT_STATUS;
      port_enable_q     <= RST_RECEIVE_STATUS[RCS_PORT_ENABLE];
      nine_bit_q        <= RST_RECEIVE_STATUS[RCS_NINE_BIT];
      single_rx_q       <= RST_RECEIVE_STATUS[RCS_SINGLE_RX];
      cont_rx_q         <= RST_RECEIVE_STATUS[RCS_CONT_RX];
      asleep_q          <= 1'b0;
    end else begin
      if (apb_write) begin
        case (paddr)
          ADDR_INTERRUPT_GLOBAL_CONTROL: int_global_q      <= pwdata[7:0];
          ADDR_PERIPHERAL_ENABLES_ONE:   periph_enables_q  <= pwdata[7:0];
          ADDR_PERIPHERAL_PRIORITY_ONE:  periph_priority_q <= pwdata[7:0];
          ADDR_BAUD_DIVISOR:             baud_divisor_q    <= pwdata[7:0];
          ADDR_TRANSMIT_STATUS_CONTROL: begin
            // Shift-register-empty is read-only; the transmit path is absent
            tx_ctrl_q <= {pwdata[7:2], 1'b1, pwdata[0]};
          end
          ADDR_RECEIVE_STATUS_CONTROL: begin
            port_enable_q <= pwdata[RCS_PORT_ENABLE];
            nine_bit_q    <= pwdata[RCS_NINE_BIT];
            single_rx_q   <= pwdata[RCS_SINGLE_RX];
            cont_rx_q     <= pwdata[RCS_CONT_RX];
          end
          ADDR_SLEEP_CONTROL: asleep_q <= pwdata[0];
          default: begin
          end
        endcase
      end
      // A wake event ends sleep
      if (wake_q) begin
        asleep_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt request and wake
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_q  <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      irq_q  <= rx_flag_q && periph_enables_q[PIE_RX_ENABLE]
                && int_global_q[ICG_GLOBAL_ENABLE] && int_global_q[ICG_PERIPH_ENABLE];
      wake_q <= asleep_q && rx_flag_q && periph_enables_q[PIE_RX_ENABLE];
    end
  end

  // ----------------------------------------------------------------
  // Read path and handshake
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          ADDR_INTERRUPT_GLOBAL_CONTROL: prdata <= {24'h00_0000, int_global_q};
          ADDR_PERIPHERAL_FLAGS_ONE: begin
            prdata <= {24'h00_0000, 2'b00, rx_flag_q, 5'b00000};
          end
          ADDR_PERIPHERAL_ENABLES_ONE:   prdata <= {24'h00_0000, periph_enables_q};
          ADDR_PERIPHERAL_PRIORITY_ONE:  prdata <= {24'h00_0000, periph_priority_q};
          ADDR_RECEIVE_STATUS_CONTROL: begin
            prdata <= {24'h00_0000, port_enable_q, nine_bit_q, single_rx_q, cont_rx_q,
                       1'b0, framing_q, overrun_q, holding_q.ninth_bit};
          end
          ADDR_RECEIVE_HOLDING:          prdata <= {24'h00_0000, holding_q.data};
          ADDR_TRANSMIT_STATUS_CONTROL:  prdata <= {24'h00_0000, tx_ctrl_q};
          ADDR_BAUD_DIVISOR:             prdata <= {24'h00_0000, baud_divisor_q};
          ADDR_SLEEP_CONTROL:            prdata <= {31'h0000_0000, asleep_q};
          default:                       prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule : sync_slave_receiver

/* design/sync_rx_pkg.sv */
// Package: register map, field positions, reset values and carrier types for the receiver
package sync_rx_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_INTERRUPT_GLOBAL_CONTROL  = 8'h00;
  localparam logic [7:0] ADDR_PERIPHERAL_FLAGS_ONE      = 8'h04;
  localparam logic [7:0] ADDR_PERIPHERAL_ENABLES_ONE    = 8'h08;
  localparam logic [7:0] ADDR_PERIPHERAL_PRIORITY_ONE   = 8'h0C;
  localparam logic [7:0] ADDR_RECEIVE_STATUS_CONTROL    = 8'h10;
  localparam logic [7:0] ADDR_RECEIVE_HOLDING           = 8'h14;
  localparam logic [7:0] ADDR_TRANSMIT_STATUS_CONTROL   = 8'h18;
  localparam logic [7:0] ADDR_BAUD_DIVISOR              = 8'h1C;
  localparam logic [7:0] ADDR_SLEEP_CONTROL             = 8'h20;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int RCS_PORT_ENABLE    = 7;
  localparam int RCS_NINE_BIT       = 6;
  localparam int RCS_SINGLE_RX      = 5;
  localparam int RCS_CONT_RX        = 4;
  localparam int RCS_FRAMING_ERR    = 2;
  localparam int RCS_OVERRUN_ERR    = 1;
  localparam int RCS_NINTH_BIT      = 0;
  localparam int TXS_CLOCK_SOURCE   = 7;
  localparam int TXS_SYNC_MODE      = 4;
  localparam int TXS_SHIFT_EMPTY    = 1;
  localparam int PIR_RX_COMPLETE    = 5;
  localparam int PIE_RX_ENABLE      = 5;
  localparam int ICG_GLOBAL_ENABLE  = 7;
  localparam int ICG_PERIPH_ENABLE  = 6;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_INTERRUPT_GLOBAL = 8'h00;
  localparam logic [7:0] RST_PERIPH_FLAGS     = 8'h00;
  localparam logic [7:0] RST_PERIPH_ENABLES   = 8'h00;
  localparam logic [7:0] RST_PERIPH_PRIORITY  = 8'h00;
  localparam logic [7:0] RST_RECEIVE_STATUS   = 8'h00;
  localparam logic [7:0] RST_RECEIVE_HOLDING  = 8'h00;
  localparam logic [7:0] RST_TRANSMIT_STATUS  = 8'h02;
  localparam logic [7:0] RST_BAUD_DIVISOR     = 8'h00;

  // ----------------------------------------------------------------
  // Counts
  // ----------------------------------------------------------------
  localparam int WORD_BITS_SHORT = 8;
  localparam int WORD_BITS_LONG  = 9;
  localparam int PIN_SYNC_STAGES = 3;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       ninth_bit;
    logic [7:0] data;
  } rx_word_type;

  typedef enum logic [2:0] {
    RX_IDLE    = 3'b001,
    RX_SHIFT   = 3'b010,
    RX_BLOCKED = 3'b100
  } rx_state_type;

endpackage : sync_rx_pkg

/* design/pin_sync.sv */
// Three-stage pin synchroniser with second/third agreement filter
module pin_sync
  import sync_rx_pkg::*;
(
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_n,
  // Pin and filtered level
  input  wire logic pin_in,
  output logic      level_q
);

  logic [PIN_SYNC_STAGES-1:0] stage_q;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      stage_q <= '0;
    end else begin
      stage_q <= {stage_q[PIN_SYNC_STAGES-2:0], pin_in};
    end
  end

  // First stage only feeds the second; a change counts once stages two and three agree
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      level_q <= 1'b0;
    end else if (stage_q[1] == stage_q[2]) begin
      level_q <= stage_q[2];
    end
  end

endmodule : pin_sync

/* design/word_buffer.sv */
// Two-entry valid/ready buffer for received words
module word_buffer
  import sync_rx_pkg::*;
#(
  parameter int WIDTH = 9
)
(
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire logic             flush,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  logic [WIDTH-1:0] slot_q [2];
  logic [1:0]       count_q;
  logic             rd_ptr_q;
  logic             wr_ptr_q;
  logic             push;
  logic             pop;

  assign in_ready  = (count_q != 2'd2);
  assign out_valid = (count_q != 2'd0);
  assign out_data  = slot_q[rd_ptr_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q  <= 2'd0;
      rd_ptr_q <= 1'b0;
      wr_ptr_q <= 1'b0;
    end else if (flush) begin
      count_q  <= 2'd0;
      rd_ptr_q <= 1'b0;
      wr_ptr_q <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_q <= ~wr_ptr_q;
      end
      if (pop) begin
        rd_ptr_q <= ~rd_ptr_q;
      end
      count_q <= count_q + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      slot_q[0] <= '0;
      slot_q[1] <= '0;
    end else if (push) begin
      slot_q[wr_ptr_q] <= in_data;
    end
  end

endmodule : word_buffer

/* sim/sync_rx_assertions.sv */
// Checker: port-level assertions for the synchronous slave receiver
module sync_rx_assertions
  import sync_rx_pkg::*;
(
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        rst_n,
  // APB slave
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Serial pins
  input wire logic        shift_clk_pin,
  input wire logic        data_pin,
  // Core sleep and events
  input wire logic        asleep_q,
  input wire logic        irq_q,
  input wire logic        wake_q
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // ----------------------------------------------------------------
  // Helper: last written receive interrupt enable
  // ----------------------------------------------------------------
  logic pie_q;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pie_q <= 1'b0;
    end else if (psel && penable && pready && pwrite && paddr == ADDR_PERIPHERAL_ENABLES_ONE) begin
      pie_q <= pwdata[PIE_RX_ENABLE];
    end
  end

  // ----------------------------------------------------------------
  // Sequences and assertions
  // ----------------------------------------------------------------
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_read;
    psel && penable && pready && !pwrite;
  endsequence

  ready_after_setup_a: assert property (s_setup |=> pready && penable)
    else $error("pready missing after setup");
  ready_one_cycle_a: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  error_with_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  upper_bits_zero_a: assert property (s_read |-> prdata[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  status_bit_three_a: assert property (s_read |->
      (paddr != ADDR_RECEIVE_STATUS_CONTROL || !prdata[3]))
    else $error("receive status bit 3 not zero");
  shift_empty_set_a: assert property (s_read |->
      (paddr != ADDR_TRANSMIT_STATUS_CONTROL || prdata[TXS_SHIFT_EMPTY]))
    else $error("shift register empty bit not set");
  irq_needs_enable_a: assert property (irq_q |-> $past(pie_q))
    else $error("interrupt without receive enable");
  wake_needs_enable_a: assert property (wake_q |-> $past(pie_q))
    else $error("wake without receive enable");
  wake_when_asleep_a: assert property (wake_q |-> $past(asleep_q))
    else $error("wake while not asleep");
  sleep_exit_a: assert property (wake_q |-> ##[1:2] !asleep_q)
    else $error("sleep not left after wake");
endmodule : sync_rx_assertions

bind sync_slave_receiver sync_rx_assertions chk_u (
  .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .shift_clk_pin(shift_clk_pin), .data_pin(data_pin), .asleep_q(asleep_q),
  .irq_q(irq_q), .wake_q(wake_q)
);

/* sim/sync_master_model.sv */
// Partner: external synchronous master driving shift clock and serial data
module sync_master_model
(
  // Serial pins
  output logic shift_clk,
  output logic data
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    shift_clk = 1'b1;
    data      = 1'b1;
  end

  // ----------------------------------------------------------------
  // One frame, LSB first, 64 ns period; clock stands high between frames
  // ----------------------------------------------------------------
  task automatic send(input logic [8:0] word, input logic nine);
    #1.7;
    for (int i = 0; i < (nine ? 9 : 8); i++) begin
      data = word[i];
      #16 shift_clk = 1'b0;
      #32 shift_clk = 1'b1;
      #16;
    end
    // Released line shows no stale bit
    data = ~data;
  endtask : send
endmodule : sync_master_model

/* sim/tb.sv */
// Testbench: APB-driven checks of the synchronous slave receiver
module tb
  import sync_rx_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic        ref_clk;
  logic        rst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        shift_clk_pin;
  logic        data_pin;
  logic        asleep_q;
  logic        irq_q;
  logic        wake_q;
  logic [31:0] rd_data;
  logic        rd_err;
  int          mismatches;
  int          checks;
  logic [7:0]  addr_tab [8] = '{ADDR_INTERRUPT_GLOBAL_CONTROL, ADDR_PERIPHERAL_FLAGS_ONE,
    ADDR_PERIPHERAL_ENABLES_ONE, ADDR_PERIPHERAL_PRIORITY_ONE, ADDR_RECEIVE_STATUS_CONTROL,
    ADDR_RECEIVE_HOLDING, ADDR_TRANSMIT_STATUS_CONTROL, ADDR_BAUD_DIVISOR};
  logic [7:0]  rst_tab [8] = '{RST_INTERRUPT_GLOBAL, RST_PERIPH_FLAGS, RST_PERIPH_ENABLES,
    RST_PERIPH_PRIORITY, RST_RECEIVE_STATUS, RST_RECEIVE_HOLDING, RST_TRANSMIT_STATUS,
    RST_BAUD_DIVISOR};

  sync_slave_receiver dut_u (
    .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .shift_clk_pin(shift_clk_pin), .data_pin(data_pin), .asleep_q(asleep_q),
    .irq_q(irq_q), .wake_q(wake_q)
  );
  sync_master_model master_u (.shift_clk(shift_clk_pin), .data(data_pin));

  always #2.5 ref_clk = ~ref_clk;

  // ----------------------------------------------------------------
  // Report and compare tasks
  // ----------------------------------------------------------------
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : test_done

  task automatic fail_wait(input string what);
    mismatches++;
    $display("mismatch %s expected completion seen timeout", what);
    test_done();
  endtask : fail_wait

  task automatic check_reg(input string name, input logic [7:0] exp, input logic [31:0] got);
    checks++;
    if (got !== {24'h000000, exp}) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : check_reg

  task automatic check_bit(input string name, input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %b seen %b", name, exp, got);
    end
  endtask : check_bit

  // ----------------------------------------------------------------
  // APB master: hold the request until pready is sampled high
  // ----------------------------------------------------------------
  task automatic apb(input logic [7:0] addr, input logic wr, input logic [31:0] wdata);
    int n;
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= wdata;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) fail_wait("pready");
    rd_data = prdata;
    rd_err  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Polls the flag register; the run fails if the flag is not set within 200 reads
  task automatic wait_flag();
    int n;
    n = 0;
    do begin
      apb(ADDR_PERIPHERAL_FLAGS_ONE, 1'b0, 32'h00000000);
      n++;
    end while (rd_data[PIR_RX_COMPLETE] !== 1'b1 && n < 200);
    if (rd_data[PIR_RX_COMPLETE] !== 1'b1) fail_wait("receive flag");
  endtask : wait_flag

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    int n;
    ref_clk = 1'b0;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    mismatches = 0;
    checks = 0;
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      apb(addr_tab[i], 1'b0, 32'h00000000);
      check_reg("reset value", rst_tab[i], rd_data);
    end
    apb(8'h24, 1'b0, 32'h00000000);
    check_bit("unmapped error", 1'b1, rd_err);
    check_reg("unmapped data", 8'h00, rd_data);
    // Single-receive alone must not start slave reception
    apb(ADDR_TRANSMIT_STATUS_CONTROL, 1'b1, 32'h00000010);
    apb(ADDR_RECEIVE_STATUS_CONTROL, 1'b1, 32'h000000A0);
    master_u.send(9'h0C3, 1'b0);
    repeat (20) @(posedge ref_clk);
    apb(ADDR_PERIPHERAL_FLAGS_ONE, 1'b0, 32'h00000000);
    check_reg("flag idle", 8'h00, rd_data);
    // Continuous receive with interrupt enabled
    apb(ADDR_INTERRUPT_GLOBAL_CONTROL, 1'b1, 32'h000000C0);
    apb(ADDR_PERIPHERAL_ENABLES_ONE, 1'b1, 32'h00000020);
    apb(ADDR_RECEIVE_STATUS_CONTROL, 1'b1, 32'h000000B0);
    master_u.send(9'h0A5, 1'b0);
    wait_flag();
    check_bit("irq", 1'b1, irq_q);
    apb(ADDR_RECEIVE_HOLDING, 1'b0, 32'h00000000);
    check_reg("holding", 8'hA5, rd_data);
    apb(ADDR_PERIPHERAL_FLAGS_ONE, 1'b0, 32'h00000000);
    check_reg("flag cleared", 8'h00, rd_data);
    // Nine-bit word with the interrupt masked
    apb(ADDR_PERIPHERAL_ENABLES_ONE, 1'b1, 32'h00000000);
    apb(ADDR_RECEIVE_STATUS_CONTROL, 1'b1, 32'h000000D0);
    master_u.send(9'h13C, 1'b1);
    wait_flag();
    check_bit("irq masked", 1'b0, irq_q);
    apb(ADDR_RECEIVE_STATUS_CONTROL, 1'b0, 32'h00000000);
    check_reg("status ninth", 8'hD1, rd_data);
    apb(ADDR_RECEIVE_HOLDING, 1'b0, 32'h00000000);
    check_reg("holding nine", 8'h3C, rd_data);
    // Word received while asleep wakes the core
    apb(ADDR_PERIPHERAL_ENABLES_ONE, 1'b1, 32'h00000020);
    apb(ADDR_SLEEP_CONTROL, 1'b1, 32'h00000001);
    repeat (2) @(posedge ref_clk);
    check_bit("asleep", 1'b1, asleep_q);
    // Wake stands only a few cycles, so it is watched while the frame runs
    fork
      master_u.send(9'h05A, 1'b1);
      begin
        n = 0;
        while (wake_q !== 1'b1 && n < 400) begin
          @(posedge ref_clk);
          n++;
        end
      end
    join
    if (wake_q !== 1'b1 && n >= 400) fail_wait("wake");
    repeat (3) @(posedge ref_clk);
    check_bit("asleep after wake", 1'b0, asleep_q);
    apb(ADDR_RECEIVE_HOLDING, 1'b0, 32'h00000000);
    check_reg("holding sleep", 8'h5A, rd_data);
    // Unread words overflow the buffer; clearing continuous receive clears the error
    apb(ADDR_RECEIVE_STATUS_CONTROL, 1'b1, 32'h00000090);
    for (int i = 0; i < 4; i++) begin
      master_u.send(9'h010 + 9'(i), 1'b0);
    end
    repeat (20) @(posedge ref_clk);
    apb(ADDR_RECEIVE_STATUS_CONTROL, 1'b0, 32'h00000000);
    check_reg("overrun", 8'h92, rd_data);
    apb(ADDR_RECEIVE_STATUS_CONTROL, 1'b1, 32'h00000080);
    apb(ADDR_RECEIVE_STATUS_CONTROL, 1'b0, 32'h00000000);
    check_reg("overrun cleared", 8'h80, rd_data);
    test_done();
  end
endmodule : tb
